/* File: shared/backlight_output_pkg.sv */
// Constants, types and carriers shared by the LED and PWM driver control
`default_nettype none
package backlight_output_pkg;
  // ==========================================================
  // Clock
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WHITE_DUTY = 8'h16;
  localparam logic [7:0] IDX_FLASH      = 8'h17;
  localparam logic [7:0] IDX_RED        = 8'h18;
  localparam logic [7:0] IDX_GREEN      = 8'h19;
  localparam logic [7:0] IDX_BLUE       = 8'h1a;
  localparam logic [7:0] IDX_PWM        = 8'h1d;
  localparam logic [7:0] IDX_BACKLIGHT  = 8'h27;
  localparam logic [7:0] IDX_RATE       = 8'h30;
  localparam logic [7:0] IDX_STATUS     = 8'h31;
  localparam logic [7:0] FLASH_RESET    = 8'h01;
  localparam logic [7:0] ZERO_RESET     = 8'h00;

  // Field positions
  localparam int F_FLASH_EN = 7;
  localparam int F_ON_HI    = 6;
  localparam int F_ON_LO    = 4;
  localparam int F_PER_HI   = 3;
  localparam int F_ISET_HI  = 7;
  localparam int F_ISET_LO  = 6;
  localparam int F_PHASE    = 5;
  localparam int F_CDUTY_HI = 4;
  localparam int F_PWM_EN   = 7;
  localparam int F_PFREQ_HI = 6;
  localparam int F_PFREQ_LO = 4;
  localparam int F_PDUTY_HI = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Burst modulators
  localparam int BURST_PULSES = 256;
  localparam int RGB_PULSES   = 32;
  localparam int WHITE_HI_HZ  = 180;
  localparam int BL_HI_HZ     = 183;
  localparam int RATE_LO_HZ   = 122;
  localparam int RGB_RATE_HZ  = 1000;
  localparam logic [11:0] WHITE_HI_CYC =
    12'(CLK_HZ / (WHITE_HI_HZ * BURST_PULSES));
  localparam logic [11:0] BL_HI_CYC =
    12'(CLK_HZ / (BL_HI_HZ * BURST_PULSES));
  localparam logic [11:0] LO_CYC =
    12'(CLK_HZ / (RATE_LO_HZ * BURST_PULSES));
  localparam logic [11:0] RGB_CYC =
    12'(CLK_HZ / (RGB_RATE_HZ * RGB_PULSES));
  localparam logic [8:0]  BURST_MID = 9'h080;

  // ==========================================================
  // Boost timing and soft start
  localparam int MAX_ON_NS  = 6000;
  localparam int MAX_ON_CYC = MAX_ON_NS / CLK_NS;
  localparam int SOFT_STEP_PULSES = 256;

  // ==========================================================
  // Flash timing in ticks of 0.1 s
  localparam int FLASH_TICK_MS      = 100;
  localparam int FLASH_TICK_CYC     = CLK_HZ / 1000 * FLASH_TICK_MS;
  localparam int FLASH_HALF_S_TICKS = 5;

  // ==========================================================
  // Open-drain PWM pin
  localparam int PWM_SLOTS = 16;
  localparam int PWM_HZ [8] = '{15600, 7800, 4500, 3000,
                                2000, 1500, 1000, 500};
  localparam logic [11:0] PWM_SLOT_CYC [8] = '{
    12'(CLK_HZ / (PWM_HZ[0] * PWM_SLOTS)),
    12'(CLK_HZ / (PWM_HZ[1] * PWM_SLOTS)),
    12'(CLK_HZ / (PWM_HZ[2] * PWM_SLOTS)),
    12'(CLK_HZ / (PWM_HZ[3] * PWM_SLOTS)),
    12'(CLK_HZ / (PWM_HZ[4] * PWM_SLOTS)),
    12'(CLK_HZ / (PWM_HZ[5] * PWM_SLOTS)),
    12'(CLK_HZ / (PWM_HZ[6] * PWM_SLOTS)),
    12'(CLK_HZ / (PWM_HZ[7] * PWM_SLOTS))};

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LIM_OFF = 2'h0, LIM_125MA = 2'h1, LIM_250MA = 2'h2, LIM_500MA = 2'h3
  } limit_e;
  typedef enum logic [3:0] {
    BOOST_OFF = 4'h1, BOOST_SOFT1 = 4'h2,
    BOOST_SOFT2 = 4'h4, BOOST_RUN = 4'h8
  } boost_e;
  typedef struct packed {
    logic fb_below_ref;
    logic peak_reached;
    logic ovp_above;
    logic ovp_below_hys;
    logic uvlo;
    logic thermal;
  } sense_s;
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } color_s;

  // Forced pulses spread by bit-reversed index
  function automatic logic burst_bit(input logic [7:0] duty,
                                     input logic [7:0] rev,
                                     input logic       half);
    logic [8:0] d9;
    logic [8:0] forced;
    d9     = {1'b0, duty};
    forced = (d9 >= BURST_MID) ? 9'((d9 - BURST_MID) << 1)
                               : 9'((BURST_MID - d9) << 1);
    if (duty == 8'h00)
      return 1'b0;
    if ({1'b0, rev} < forced)
      return d9 >= BURST_MID;
    return half;
  endfunction
endpackage
`default_nettype wire

/* File: verilog/backlight_output_driver_control.sv */
// LED boost, backlight, RGB and PWM pin control behind AXI4-Lite
// What this block does
// - White switch is burst of pulses, 50% each
// - Force pulses full on or off to shift
// - 256 pulses per period, 0.4% step
// - White rate 180 Hz high, 122 Hz low
// - Backlight rate 183 Hz high, 122 Hz low
// - Zero white duty keeps boost off
// - Nonzero duty enables boost via soft start
// - Soft start limits 125, 250, 500 mA
// - Switch on when feedback low, LED on
// - Switch off on peak, 6 us, LED off
// - Overvoltage holds switch off with hysteresis
// - Undervoltage lockout forces boost off, switches open
// - Thermal shutdown forces boost off, switches open
// - LED switch open while boost shut down
// - PWM pin: eight frequencies, sixteen duties
// - PWM pin frequencies 500 Hz to 15.6 kHz
// - Backlight duty 0.4..99.6%, zero is off
// - Color sinks off unless flash enabled
// - Flash period 1..8 s, or continuous
// - Color burst of 32 pulses, 3.125% step
// - Shared color current 4, 8, 12 mA
// - Shared flash settings and phase delay
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`default_nettype none

// ============================================================
// Burst-pulse modulator channel
module burst_mod #(
  parameter int IDX_W = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] period,
  input  wire logic [7:0]  duty,
  output logic             level
);
  import backlight_output_pkg::*;
  logic [11:0]      pre;
  logic [IDX_W-1:0] idx;
  logic [7:0]       shadow;
  logic [IDX_W-1:0] rev_idx;
  logic [7:0]       rev8;
  wire logic        pulse_end = pre >= period - 12'h001;
  wire logic        frame_end = pulse_end && (idx == {IDX_W{1'b1}});
  // An idle channel starts a fresh period at once, no dark frame first
  wire logic        restart = shadow == 8'h00 && duty != 8'h00;

  assign rev_idx = {<<{idx}};
  assign rev8    = 8'(rev_idx) << (8 - IDX_W);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre    <= 12'h000;
      idx    <= '0;
      shadow <= 8'h00;
      level  <= 1'b0;
    end else if (restart) begin
      pre    <= 12'h000;
      idx    <= '0;
      shadow <= duty;
      level  <= 1'b0;
    end else begin
      pre <= pulse_end ? 12'h000 : pre + 12'h001;
      if (pulse_end)
        idx <= idx + 1'b1;
      // Avoids a half-old, half-new pattern
      if (frame_end)
        shadow <= duty;
      level <= burst_bit(shadow, rev8, pre < (period >> 1));
    end
  end
endmodule

// ============================================================
// Top level
module backlight_output_driver_control #(
  parameter int FLASH_TICK_CYCLES = backlight_output_pkg::FLASH_TICK_CYC
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire backlight_output_pkg::sense_s sense,
  output logic                     power_switch,
  output logic                     led_switch,
  output backlight_output_pkg::limit_e      current_limit,
  input  wire logic                backlight_in,
  output logic                     backlight_out,
  output logic                     backlight_oe,
  input  wire logic                pwm_pin_in,
  output logic                     pwm_pin_out,
  output logic                     pwm_pin_oe,
  output backlight_output_pkg::color_s      color_sink,
  output logic [1:0]               color_current_sel
);
  import backlight_output_pkg::*;

  // ==========================================================
  // Input synchronisers with agreement filter
  localparam int SYNC_W = $bits(sense_s) + 2;
  logic [SYNC_W-1:0] s1, s2, s3, filt;
  sense_s            sf;
  logic              bl_pin_f, pwm_pin_f;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      filt <= '0;
    end else begin
      s1   <= {sense, backlight_in, pwm_pin_in};
      s2   <= s1;
      s3   <= s2;
      filt <= (s2 & s3) | (filt & (s2 | s3));
    end
  end
  assign sf        = sense_s'(filt[SYNC_W-1:2]);
  assign bl_pin_f  = filt[1];
  assign pwm_pin_f = filt[0];

  // ==========================================================
  // Registers and AXI4-Lite slave
  logic [7:0]  white_duty_reg, color_flash_reg, color_red_duty_reg;
  logic [7:0]  color_green_duty_reg, color_blue_duty_reg;
  logic [7:0]  pwm_reg, backlight_duty_reg;
  logic        burst_rate_select_bit;
  logic        aw_held, w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic        w_lane0_q;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [8:0]  status_word;
  wire logic [7:0] wr_idx = {2'b00, aw_addr_q[7:2]};
  wire logic [7:0] rd_idx = {2'b00, araddr[7:2]};
  wire logic       wr_fire = aw_held && w_held && !bvalid;
  wire logic       wr_hit = wr_idx == IDX_WHITE_DUTY
    || wr_idx == IDX_FLASH || wr_idx == IDX_RED || wr_idx == IDX_GREEN
    || wr_idx == IDX_BLUE || wr_idx == IDX_PWM
    || wr_idx == IDX_BACKLIGHT || wr_idx == IDX_RATE
    || wr_idx == IDX_STATUS;
  wire logic       ar_fire = arvalid && arready;

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held    <= 1'b1;
        w_data_q  <= wdata;
        w_lane0_q <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      white_duty_reg        <= ZERO_RESET;
      color_flash_reg       <= FLASH_RESET;
      color_red_duty_reg    <= ZERO_RESET;
      color_green_duty_reg  <= ZERO_RESET;
      color_blue_duty_reg   <= ZERO_RESET;
      pwm_reg               <= ZERO_RESET;
      backlight_duty_reg    <= ZERO_RESET;
      burst_rate_select_bit <= 1'b0;
    end else if (wr_fire && w_lane0_q) begin
      case (wr_idx)
        IDX_WHITE_DUTY: white_duty_reg       <= w_data_q[7:0];
        IDX_FLASH:      color_flash_reg      <= w_data_q[7:0];
        IDX_RED:        color_red_duty_reg   <= w_data_q[7:0];
        IDX_GREEN:      color_green_duty_reg <= w_data_q[7:0];
        IDX_BLUE:       color_blue_duty_reg  <= w_data_q[7:0];
        IDX_PWM:        pwm_reg              <= w_data_q[7:0];
        IDX_BACKLIGHT:  backlight_duty_reg   <= w_data_q[7:0];
        IDX_RATE:       burst_rate_select_bit <= w_data_q[0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (rd_idx)
      IDX_WHITE_DUTY: rd_word[7:0] = white_duty_reg;
      IDX_FLASH:      rd_word[7:0] = color_flash_reg;
      IDX_RED:        rd_word[7:0] = color_red_duty_reg;
      IDX_GREEN:      rd_word[7:0] = color_green_duty_reg;
      IDX_BLUE:       rd_word[7:0] = color_blue_duty_reg;
      IDX_PWM:        rd_word[7:0] = pwm_reg;
      IDX_BACKLIGHT:  rd_word[7:0] = backlight_duty_reg;
      IDX_RATE:       rd_word[0]   = burst_rate_select_bit;
      IDX_STATUS:     rd_word[8:0] = status_word;
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready)
      rvalid <= 1'b0;
  end

  // ==========================================================
  // Burst modulators: white switch, backlight, color sinks
  logic       white_bit, bl_bit;
  logic [2:0] color_bit;
  wire logic [11:0] white_period =
    burst_rate_select_bit ? WHITE_HI_CYC : LO_CYC;
  wire logic [11:0] bl_period =
    burst_rate_select_bit ? BL_HI_CYC : LO_CYC;
  wire logic [4:0] color_duty [3] = '{
    color_red_duty_reg[F_CDUTY_HI:0],
    color_green_duty_reg[F_CDUTY_HI:0],
    color_blue_duty_reg[F_CDUTY_HI:0]};

  // 256-pulse frames for white and backlight, 32-pulse frames for the colors, even spreading inside burst_mod
  burst_mod #(.IDX_W(8)) u_white (
    .aclk    (aclk),
    .aresetn (aresetn),
    .period  (white_period),
    .duty    (white_duty_reg),
    .level   (white_bit)
  );
  burst_mod #(.IDX_W(8)) u_backlight (
    .aclk    (aclk),
    .aresetn (aresetn),
    .period  (bl_period),
    .duty    (backlight_duty_reg),
    .level   (bl_bit)
  );
  for (genvar c = 0; c < 3; c++) begin : g_color
    burst_mod #(.IDX_W(5)) u_color (
      .aclk    (aclk),
      .aresetn (aresetn),
      .period  (RGB_CYC),
      .duty    ({color_duty[c], 3'b000}),
      .level   (color_bit[2-c])
    );
  end

  // ==========================================================
  // Boost converter sequencing
  boost_e     boost_state, next_boost_state;
  logic [7:0] soft_cnt;
  logic [7:0] on_cnt;
  logic       ovp_block;
  wire logic  enable_ok = white_duty_reg != ZERO_RESET
    && !sf.uvlo && !sf.thermal;
  wire logic  boost_on = boost_state != BOOST_OFF;
  wire logic  sw_start = !power_switch && enable_ok && boost_on
    && sf.fb_below_ref && led_switch
    && !ovp_block && !sf.peak_reached;
  wire logic  sw_stop = sf.peak_reached || !led_switch || ovp_block
    || on_cnt >= 8'(MAX_ON_CYC - 1) || !enable_ok || !boost_on;
  wire logic  soft_last = sw_start && soft_cnt == 8'(SOFT_STEP_PULSES - 1);

  always_comb begin
    next_boost_state = boost_state;
    case (boost_state)
      BOOST_OFF:   if (enable_ok) next_boost_state = BOOST_SOFT1;
      BOOST_SOFT1: if (!enable_ok) next_boost_state = BOOST_OFF;
                   else if (soft_last) next_boost_state = BOOST_SOFT2;
      BOOST_SOFT2: if (!enable_ok) next_boost_state = BOOST_OFF;
                   else if (soft_last) next_boost_state = BOOST_RUN;
      BOOST_RUN:   if (!enable_ok) next_boost_state = BOOST_OFF;
      default:     next_boost_state = BOOST_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boost_state  <= BOOST_OFF;
      soft_cnt     <= 8'h00;
      on_cnt       <= 8'h00;
      power_switch <= 1'b0;
      led_switch   <= 1'b0;
      ovp_block    <= 1'b0;
    end else begin
      boost_state <= next_boost_state;
      if (next_boost_state != boost_state)
        soft_cnt <= 8'h00;
      else if (sw_start)
        soft_cnt <= soft_cnt + 8'h01;
      power_switch <= power_switch ? !sw_stop : sw_start;
      on_cnt       <= power_switch ? on_cnt + 8'h01 : 8'h00;
      // Opens the string whenever the boost is down
      led_switch   <= enable_ok && boost_on && white_bit;
      if (sf.ovp_above)
        ovp_block <= 1'b1;
      else if (sf.ovp_below_hys)
        ovp_block <= 1'b0;
    end
  end

  always_comb begin
    case (boost_state)
      BOOST_SOFT1: current_limit = LIM_125MA;
      BOOST_SOFT2: current_limit = LIM_250MA;
      BOOST_RUN:   current_limit = LIM_500MA;
      default:     current_limit = LIM_OFF;
    endcase
  end

  assign status_word = {pwm_pin_f, bl_pin_f, led_switch, power_switch,
                        ovp_block, boost_state};

  // ==========================================================
  // Backlight open-drain pin, low while the pulse is on
  assign backlight_out = 1'b0;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      backlight_oe <= 1'b0;
    else
      backlight_oe <= bl_bit;
  end

  // ==========================================================
  // Color flash timing
  logic [31:0] tick_cnt;
  logic [6:0]  flash_cnt;
  wire logic       flash_en = color_flash_reg[F_FLASH_EN];
  wire logic [3:0] per_code = color_flash_reg[F_PER_HI:0];
  wire logic       continuous = per_code == 4'h0;
  wire logic [6:0] per_ticks = 7'(FLASH_HALF_S_TICKS * (per_code + 1));
  wire logic [6:0] on_ticks =
    7'(color_flash_reg[F_ON_HI:F_ON_LO]) + 7'h01;
  wire logic [6:0] half_ticks = per_ticks >> 1;
  wire logic [6:0] shift_cnt = (flash_cnt + half_ticks >= per_ticks)
    ? flash_cnt + half_ticks - per_ticks : flash_cnt + half_ticks;
  wire logic       win_main = continuous || flash_cnt < on_ticks;
  wire logic       win_shift = continuous || shift_cnt < on_ticks;
  wire logic       phase_sel = color_red_duty_reg[F_PHASE];
  wire logic [1:0] iset = color_red_duty_reg[F_ISET_HI:F_ISET_LO];
  wire logic       tick = tick_cnt >= 32'(FLASH_TICK_CYCLES - 1);
  // Phase bit picks which channel runs half a period late
  wire color_s     next_color = '{
    red:   color_bit[2] && win_main,
    green: color_bit[1] && (phase_sel ? win_main : win_shift),
    blue:  color_bit[0] && (phase_sel ? win_shift : win_main)};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt          <= 32'h0000_0000;
      flash_cnt         <= 7'h00;
      color_sink        <= '0;
      color_current_sel <= 2'h0;
    end else begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (tick)
        flash_cnt <= (flash_cnt + 7'h01 >= per_ticks) ? 7'h00
                                                      : flash_cnt + 7'h01;
      // Common enable, current and timing for all three sinks
      color_sink <= (flash_en && iset != 2'h0) ? next_color
                                               : '0;
      color_current_sel <= iset;
    end
  end

  // ==========================================================
  // Open-drain PWM pin
  logic [11:0] pwm_pre;
  logic [3:0]  pwm_slot;
  wire logic [2:0]  pwm_freq = pwm_reg[F_PFREQ_HI:F_PFREQ_LO];
  wire logic [11:0] slot_cyc = PWM_SLOT_CYC[pwm_freq];
  wire logic        slot_end = pwm_pre >= slot_cyc - 12'h001;
  assign pwm_pin_out = 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_pre    <= 12'h000;
      pwm_slot   <= 4'h0;
      pwm_pin_oe <= 1'b0;
    end else begin
      pwm_pre <= slot_end ? 12'h000 : pwm_pre + 12'h001;
      if (slot_end)
        pwm_slot <= pwm_slot + 4'h1;
      pwm_pin_oe <= pwm_reg[F_PWM_EN]
                    && pwm_slot <= pwm_reg[F_PDUTY_HI:0];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_enable;
    boost_state == BOOST_OFF && enable_ok;
  endsequence
  sequence s_soft_step;
    boost_state == BOOST_SOFT1 ##1 boost_state == BOOST_SOFT2;
  endsequence

  a_zero_duty_off: assert property (white_duty_reg == ZERO_RESET
    |=> boost_state == BOOST_OFF)
    else $error("boost left off state with zero duty");
  a_enable_soft: assert property (s_enable
    |=> boost_state == BOOST_SOFT1)
    else $error("enable did not start soft start");
  a_soft_count: assert property (s_soft_step
    |-> $past(soft_cnt) == 8'(SOFT_STEP_PULSES - 1)
        && current_limit == LIM_250MA)
    else $error("soft start step length wrong");
  a_switch_start: assert property ($rose(power_switch)
    |-> $past(sf.fb_below_ref) && $past(led_switch))
    else $error("power switch started without feedback low");
  a_max_on_time: assert property (power_switch
    |-> on_cnt < 8'(MAX_ON_CYC))
    else $error("power switch on beyond max on-time");
  a_peak_stop: assert property (power_switch && sf.peak_reached
    |=> !power_switch)
    else $error("power switch not off at peak current");
  a_ovp_hold: assert property (ovp_block
    |=> !power_switch)
    else $error("power switch on during overvoltage");
  a_fault_open: assert property (sf.uvlo || sf.thermal
    |=> boost_state == BOOST_OFF && !power_switch && !led_switch)
    else $error("fault did not open both switches");
  a_off_led_open: assert property (boost_state == BOOST_OFF
    |=> !led_switch)
    else $error("led switch closed while boost off");
  a_color_gate: assert property (!flash_en
    |=> color_sink == '0)
    else $error("color sink active with flash disabled");
  // Watches the latched duty: a new register value waits for frame end unless the channel is idle
  a_backlight_zero: assert property (
    u_backlight.shadow == ZERO_RESET |=> !bl_bit)
    else $error("backlight active while duty zero");
endmodule
`default_nettype wire

/* File: verif/led_string_model.sv */
// Model of the LED string and boost inductor seen by the control block
`default_nettype none
module led_string_model (
  input  wire logic                aclk,
  input  wire logic                power_switch,
  input  wire logic                uvlo,
  input  wire logic                ovp,
  output backlight_output_pkg::sense_s      sense
);
  timeunit 1ns;
  timeprecision 1ns;
  import backlight_output_pkg::*;
  logic [3:0] on_cnt;
  // Inductor reaches its peak a few cycles after the switch closes
  always @(posedge aclk)
    on_cnt <= power_switch ? on_cnt + 4'h1 : 4'h0;
  assign sense = '{fb_below_ref: 1'b1, peak_reached: (on_cnt >= 4'h4),
                   ovp_above: ovp, ovp_below_hys: !ovp, uvlo: uvlo,
                   thermal: 1'b0};
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the LED and PWM driver control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import backlight_output_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_val;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, rd_resp, color_current_sel;
  logic uvlo = 0, ovp = 0, power_switch, led_switch, bl_oe, pwm_oe;
  sense_s sense;
  limit_e current_limit;
  color_s color_sink;
  int failures = 0, checked = 0, n;
  always #25 aclk = ~aclk;
  led_string_model i_led_string_model (.aclk(aclk),
    .power_switch(power_switch), .uvlo(uvlo), .ovp(ovp), .sense(sense));
  backlight_output_driver_control #(.FLASH_TICK_CYCLES(20)) i_backlight_output_driver_control (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .sense(sense),
    .power_switch(power_switch), .led_switch(led_switch),
    .current_limit(current_limit), .backlight_in(!bl_oe),
    .backlight_out(), .backlight_oe(bl_oe), .pwm_pin_in(!pwm_oe),
    .pwm_pin_out(), .pwm_pin_oe(pwm_oe), .color_sink(color_sink),
    .color_current_sel(color_current_sel));
  task chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    awaddr <= {idx[5:0], 2'b00}; wdata <= {24'h0, d}; wstrb <= 4'hf;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    chk("write answer", n < 50, 1'b1);
    bready <= 0;
  endtask
  task rd(input logic [7:0] idx);
    araddr <= {idx[5:0], 2'b00}; arvalid <= 1; rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    chk("read answer", n < 50, 1'b1);
    rd_val = rdata; rd_resp = rresp; rready <= 0;
  endtask
  task automatic wait_for(input logic val, ref logic sig);
    for (n = 0; n < 3000 && sig !== val; n++) @(posedge aclk);
  endtask
  task t_reset;
    rd(IDX_FLASH); chk("flash reset", rd_val, 32'h1);
    rd(IDX_STATUS); chk("boost off", rd_val[3:0], 32'h1);
    chk("sinks off", color_sink, 3'h0);
    rd(8'h3f); chk("unmapped", rd_resp, RESP_SLVERR);
  endtask
  task t_boost;
    wr(IDX_WHITE_DUTY, 8'h80);
    repeat (8) @(posedge aclk);
    chk("soft limit", current_limit, LIM_125MA);
    wait_for(1'b1, power_switch);
    chk("switch on", led_switch, 1'b1);
    repeat (9) @(posedge aclk);
    chk("peak off", power_switch, 1'b0);
    for (n = 0; n < 15000 && current_limit != LIM_250MA; n++)
      @(posedge aclk);
    chk("soft step", current_limit, LIM_250MA);
    for (n = 0; n < 15000 && current_limit != LIM_500MA; n++)
      @(posedge aclk);
    chk("run limit", current_limit, LIM_500MA);
    rd(IDX_STATUS); chk("run state", rd_val[3:0], BOOST_RUN);
  endtask
  task t_fault;
    ovp <= 1;
    repeat (10) @(posedge aclk);
    chk("ovp power", power_switch, 1'b0);
    rd(IDX_STATUS); chk("ovp block", rd_val[4], 1'b1);
    ovp <= 0;
    wait_for(1'b1, power_switch);
    chk("ovp resume", power_switch, 1'b1);
    uvlo <= 1;
    repeat (10) @(posedge aclk);
    chk("uvlo power", power_switch, 1'b0);
    chk("uvlo led", led_switch, 1'b0);
    chk("uvlo limit", current_limit, LIM_OFF);
    uvlo <= 0;
  endtask
  task t_drivers;
    int ones;
    wr(IDX_BACKLIGHT, 8'hff);
    wr(IDX_RED, 8'h5f);
    wr(IDX_FLASH, 8'h80);
    wr(IDX_PWM, 8'h83);
    repeat (8) @(posedge aclk);
    chk("backlight on", bl_oe, 1'b1);
    chk("red sink only", color_sink, 3'h4);
    chk("color current", color_current_sel, 2'h1);
    rd(IDX_STATUS); chk("backlight pin", rd_val[7], 1'b0);
    ones = 0;
    repeat (16 * PWM_SLOT_CYC[0]) begin
      @(posedge aclk);
      ones += pwm_oe;
    end
    chk("pwm duty", ones, 4 * PWM_SLOT_CYC[0]);
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_boost;
    t_fault;
    t_drivers;
    end_of_test;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    end_of_test;
  end
endmodule
`default_nettype wire
